/* rtl/csbc_top.sv */
// Chip select region start and mode registers with region decode
//
// Notes on behaviour
// - Start registers hold address bits 23..15 in bits 15..7, read/write.
// - Start registers hold address bit 11 in bit 3, read/write.
// - Start bits 6..4 and 2..0 read zero and ignore writes.
// - Reset loads region 1 start with 0080h and region 2 with 8080h.
// - Writing region 2 start as all zeros makes region 1 reach FFFFFFh.
// - Zeroing region 1 start gives no special extension.
`timescale 1ns/1ns
module csbc_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [23:0] ext_addr,
  output logic region1_sel,
  output logic region2_sel,
  output logic region2_zeroed,
  output logic [1:0] ack_mode_sel1,
  output logic [2:0] alt_master_wait1,
  output logic [1:0] data_setup_wait1,
  output logic [3:0] strobe_wait1,
  output logic [1:0] data_hold_wait1,
  output logic [1:0] ack_mode_sel2,
  output logic [2:0] alt_master_wait2,
  output logic [1:0] data_setup_wait2,
  output logic [3:0] strobe_wait2,
  output logic [1:0] data_hold_wait2
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] region1_start;
    logic [15:0] region2_start;
    logic [15:0] mode1;
    logic [15:0] mode2;
    logic zeroed;
    logic [15:0] rdata;
    logic sel1;
    logic sel2;
  } csbc_state_s;

  csbc_state_s st_q;
  csbc_state_s st_d;
  logic ge1;
  logic ge2;
  logic [23:0] start2_addr;

  // ----------------------------------------
  // Port decode and data path
  // ----------------------------------------
  logic wr_start1;
  logic wr_start2;
  logic wr_mode1;
  logic wr_mode2;
  logic rd_start1;
  logic rd_start2;
  logic rd_mode1;
  logic rd_mode2;
  logic rd_status;
  logic [15:0] start_wdata;
  logic [15:0] mode_wdata;
  logic wdata_zero;
  logic [15:0] status_word;
  logic [15:0] rd_word;

  // ----------------------------------------
  // Select path
  // ----------------------------------------
  logic sel1_nx;
  logic sel2_nx;

  // ----------------------------------------
  // Region comparators
  // ----------------------------------------
  csbc_region_cmp u_cmp1 (
    .start_reg(st_q.region1_start),
    .ext_addr(ext_addr),
    .at_or_above(ge1),
    .start_addr()
  );

  csbc_region_cmp u_cmp2 (
    .start_reg(st_q.region2_start),
    .ext_addr(ext_addr),
    .at_or_above(ge2),
    .start_addr(start2_addr)
  );

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Unmapped indices decode to nothing, so their writes fall away
  always_comb begin
    wr_start1 = 1'b0;
    wr_start2 = 1'b0;
    wr_mode1 = 1'b0;
    wr_mode2 = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        csbc_pkg::ADDR_REGION1_START: begin
          wr_start1 = 1'b1;
        end
        csbc_pkg::ADDR_REGION2_START: begin
          wr_start2 = 1'b1;
        end
        csbc_pkg::ADDR_REGION1_MODE: begin
          wr_mode1 = 1'b1;
        end
        csbc_pkg::ADDR_REGION2_MODE: begin
          wr_mode2 = 1'b1;
        end
        default: begin
          wr_start1 = 1'b0;
          wr_start2 = 1'b0;
          wr_mode1 = 1'b0;
          wr_mode2 = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  // Decoded once so the read mux stays a flat select
  always_comb begin
    rd_start1 = 1'b0;
    rd_start2 = 1'b0;
    rd_mode1 = 1'b0;
    rd_mode2 = 1'b0;
    rd_status = 1'b0;
    if (reg_rd) begin
      case (reg_addr)
        csbc_pkg::ADDR_REGION1_START: begin
          rd_start1 = 1'b1;
        end
        csbc_pkg::ADDR_REGION2_START: begin
          rd_start2 = 1'b1;
        end
        csbc_pkg::ADDR_REGION1_MODE: begin
          rd_mode1 = 1'b1;
        end
        csbc_pkg::ADDR_REGION2_MODE: begin
          rd_mode2 = 1'b1;
        end
        csbc_pkg::ADDR_DECODE_STATUS: begin
          rd_status = 1'b1;
        end
        default: begin
          rd_start1 = 1'b0;
          rd_start2 = 1'b0;
          rd_mode1 = 1'b0;
          rd_mode2 = 1'b0;
          rd_status = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Write data shaping
  // ----------------------------------------
  // Masking here keeps unimplemented bits at zero for every reader
  assign start_wdata = reg_wdata & csbc_pkg::START_IMPL_MASK;
  assign mode_wdata = reg_wdata & csbc_pkg::MODE_IMPL_MASK;
  // Whole word compared, so a partial zero never arms it
  assign wdata_zero = (reg_wdata == csbc_pkg::START_ALL_ZERO);

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  assign status_word = {13'h0000, st_q.zeroed, st_q.sel2, st_q.sel1};

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  always_comb begin
    rd_word = '0;
    if (rd_start1) begin
      rd_word = st_q.region1_start;
    end
    if (rd_start2) begin
      rd_word = st_q.region2_start;
    end
    if (rd_mode1) begin
      rd_word = st_q.mode1;
    end
    if (rd_mode2) begin
      rd_word = st_q.mode2;
    end
    if (rd_status) begin
      rd_word = status_word;
    end
  end

  // ----------------------------------------
  // Region 1 select
  // ----------------------------------------
  // Registered selects cost a cycle but keep the pins glitch free
  always_comb begin
    if (st_q.zeroed) begin
      sel1_nx = ge1 && (ext_addr <= csbc_pkg::EXT_ADDR_TOP);
    end else begin
      sel1_nx = ge1 && (ext_addr < start2_addr);
    end
  end

  // ----------------------------------------
  // Region 2 select
  // ----------------------------------------
  // Region 2 runs to the top of the external space
  always_comb begin
    if (st_q.zeroed) begin
      sel2_nx = 1'b0;
    end else begin
      sel2_nx = ge2;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    if (wr_start1) begin
      // No zero special case here, by design
      st_d.region1_start = start_wdata;
    end

    if (wr_start2) begin
      st_d.region2_start = start_wdata;
      st_d.zeroed = wdata_zero;
    end

    if (wr_mode1) begin
      st_d.mode1 = mode_wdata;
    end

    if (wr_mode2) begin
      st_d.mode2 = mode_wdata;
    end
    // Idle reads return zero, so a stale word never looks fresh
    st_d.rdata = rd_word;
    st_d.sel1 = sel1_nx;
    st_d.sel2 = sel2_nx;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q.region1_start <= csbc_pkg::REGION1_START_RST;
      st_q.region2_start <= csbc_pkg::REGION2_START_RST;
      st_q.mode1 <= csbc_pkg::MODE_RST;
      st_q.mode2 <= csbc_pkg::MODE_RST;
      st_q.zeroed <= 1'b0;
      st_q.rdata <= '0;
      st_q.sel1 <= 1'b0;
      st_q.sel2 <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Read data and selects
  // ----------------------------------------
  // Clock enable low holds all of these, read data too
  always_comb begin
    reg_rdata = st_q.rdata;
    region1_sel = st_q.sel1;
    region2_sel = st_q.sel2;
    region2_zeroed = st_q.zeroed;
  end

  // ----------------------------------------
  // Region 1 mode fields
  // ----------------------------------------
  always_comb begin
    ack_mode_sel1 = st_q.mode1[csbc_pkg::ACK_MSB:csbc_pkg::ACK_LSB];
    alt_master_wait1 = st_q.mode1[csbc_pkg::AMW_MSB:csbc_pkg::AMW_LSB];
    data_setup_wait1 = st_q.mode1[csbc_pkg::DSW_MSB:csbc_pkg::DSW_LSB];
    strobe_wait1 = st_q.mode1[csbc_pkg::STW_MSB:csbc_pkg::STW_LSB];
    data_hold_wait1 = st_q.mode1[csbc_pkg::DHW_MSB:csbc_pkg::DHW_LSB];
  end

  // ----------------------------------------
  // Region 2 mode fields
  // ----------------------------------------
  always_comb begin
    ack_mode_sel2 = st_q.mode2[csbc_pkg::ACK_MSB:csbc_pkg::ACK_LSB];
    alt_master_wait2 = st_q.mode2[csbc_pkg::AMW_MSB:csbc_pkg::AMW_LSB];
    data_setup_wait2 = st_q.mode2[csbc_pkg::DSW_MSB:csbc_pkg::DSW_LSB];
    strobe_wait2 = st_q.mode2[csbc_pkg::STW_MSB:csbc_pkg::STW_LSB];
    data_hold_wait2 = st_q.mode2[csbc_pkg::DHW_MSB:csbc_pkg::DHW_LSB];
  end
endmodule

/* common/csbc_pkg.sv */
// Package of constants for the chip select base configuration block
package csbc_pkg;
  // ----------------------------------------
  // Register offsets (word index on the register port)
  // ----------------------------------------
  localparam logic [2:0] ADDR_REGION1_START = 3'h0;
  localparam logic [2:0] ADDR_REGION2_START = 3'h1;
  localparam logic [2:0] ADDR_REGION1_MODE = 3'h2;
  localparam logic [2:0] ADDR_REGION2_MODE = 3'h3;
  localparam logic [2:0] ADDR_DECODE_STATUS = 3'h4;
  // ----------------------------------------
  // Start register layout
  // ----------------------------------------
  localparam logic [15:0] START_IMPL_MASK = 16'hff88;
  localparam logic [15:0] REGION1_START_RST = 16'h0080;
  localparam logic [15:0] REGION2_START_RST = 16'h8080;
  localparam logic [15:0] START_ALL_ZERO = 16'h0000;
  localparam int START_HI_MSB = 15;
  localparam int START_HI_LSB = 7;
  localparam int START_B11_POS = 3;
  // ----------------------------------------
  // Mode register layout
  // ----------------------------------------
  localparam logic [15:0] MODE_IMPL_MASK = 16'hf8ff;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam int ACK_MSB = 15;
  localparam int ACK_LSB = 14;
  localparam int AMW_MSB = 13;
  localparam int AMW_LSB = 11;
  localparam int DSW_MSB = 7;
  localparam int DSW_LSB = 6;
  localparam int STW_MSB = 5;
  localparam int STW_LSB = 2;
  localparam int DHW_MSB = 1;
  localparam int DHW_LSB = 0;
  // ----------------------------------------
  // External address layout
  // ----------------------------------------
  localparam int EXT_ADDR_W = 24;
  localparam logic [23:0] EXT_ADDR_TOP = 24'hffffff;
endpackage

/* rtl/csbc_region_cmp.sv */
// Compares an external address against a region start value
`timescale 1ns/1ns
module csbc_region_cmp (
  input wire logic [15:0] start_reg,
  input wire logic [23:0] ext_addr,
  output logic at_or_above,
  output logic [23:0] start_addr
);
  // ----------------------------------------
  // Start address from register fields
  // ----------------------------------------
  always_comb begin
    start_addr = '0;
    start_addr[23:15] = start_reg[csbc_pkg::START_HI_MSB:
                                  csbc_pkg::START_HI_LSB];
    start_addr[11] = start_reg[csbc_pkg::START_B11_POS];
    at_or_above = (ext_addr >= start_addr);
  end
endmodule

/* verif/csbc_chk_asserts.sv */
// Checker for the chip select configuration ports
`timescale 1ns/1ns
module csbc_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [23:0] ext_addr,
  input wire logic region1_sel,
  input wire logic region2_sel,
  input wire logic region2_zeroed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0)
    else $error("read data not idle");
  AST_START_UNIMP: assert property (
    clk_en && reg_rd && reg_addr < 3'h2 |=> (reg_rdata & 16'h0077) == 16'h0)
    else $error("start unimplemented bits set");
  AST_MODE_UNIMP: assert property (
    clk_en && reg_rd && reg_addr == 3'h2 |=> reg_rdata[10:8] == 3'h0)
    else $error("mode unimplemented bits set");
  AST_SEL_EXCL: assert property (!(region1_sel && region2_sel))
    else $error("both selects high");
  AST_ZERO_SET: assert property (
    clk_en && reg_wr && reg_addr == 3'h1
    |=> region2_zeroed == ($past(reg_wdata) == 16'h0))
    else $error("zeroed flag wrong");
  AST_ZERO_HOLD: assert property (
    clk_en && !(reg_wr && reg_addr == 3'h1) |=> $stable(region2_zeroed))
    else $error("zeroed flag moved");
  AST_ZERO_NO_SEL2: assert property (
    region2_zeroed && $past(region2_zeroed) && $past(clk_en) |-> !region2_sel)
    else $error("region 2 selected while zeroed");
  AST_TOP_SEL1: assert property (
    clk_en && region2_zeroed && ext_addr == 24'hffffff |=> region1_sel)
    else $error("region 1 misses top");
endmodule
bind csbc_top csbc_chk u_chk (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .ext_addr, .region1_sel, .region2_sel,
  .region2_zeroed);

/* verif/csbc_mem_model.sv */
// Two external devices answering on their chip selects
`timescale 1ns/1ns
module csbc_mem_model (
  input wire logic region1_sel,
  input wire logic region2_sel,
  output logic [1:0] dev_hit
);
  // Both at once would clash on the data bus
  assign dev_hit = {region2_sel, region1_sel};
endmodule

/* verif/tb_chip_select_base_config.sv */
// Self-checking bench for the chip select configuration block
`timescale 1ns/1ns
module tb_chip_select_base_config;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [23:0] ext_addr = 24'h0;
  logic [15:0] reg_rdata;
  logic clk_en = 1'b1;
  logic [12:0] mode1;
  logic [12:0] mode2;
  logic [1:0] hit;
  logic sel1, sel2, zeroed;
  int mismatches = 0;
  int compares = 0;
  always #25 sys_clk = ~sys_clk;
  csbc_top u_dut (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .ext_addr, .region1_sel(sel1),
    .region2_sel(sel2), .region2_zeroed(zeroed),
    .ack_mode_sel1(mode1[12:11]), .alt_master_wait1(mode1[10:8]),
    .data_setup_wait1(mode1[7:6]), .strobe_wait1(mode1[5:2]),
    .data_hold_wait1(mode1[1:0]), .ack_mode_sel2(mode2[12:11]),
    .alt_master_wait2(mode2[10:8]), .data_setup_wait2(mode2[7:6]),
    .strobe_wait2(mode2[5:2]), .data_hold_wait2(mode2[1:0]));
  csbc_mem_model u_mem (.region1_sel(sel1), .region2_sel(sel2), .dev_hit(hit));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk({8'h0, reg_rdata}, {8'h0, exp});
    @(posedge sys_clk);
  endtask
  task automatic dec(input logic [23:0] a, input logic [1:0] exp);
    ext_addr <= a;
    @(posedge sys_clk);
    #1 chk({22'h0, hit}, {22'h0, exp});
    @(posedge sys_clk);
  endtask
  task automatic t_fields;
    rd(3'h0, 16'h0080);
    rd(3'h1, 16'h8080);
    wr(3'h0, 16'hffff);
    rd(3'h0, 16'hff88);
    wr(3'h0, 16'h0008);
    rd(3'h0, 16'h0008);
    wr(3'h2, 16'hffff);
    rd(3'h2, 16'hf8ff);
    chk({11'h0, mode1}, 24'h001fff);
    rd(3'h7, 16'h0000);
    $display("test fields done");
  endtask
  task automatic t_freeze;
    // Write with the enable low must not land
    clk_en <= 1'b0;
    wr(3'h3, 16'hffff);
    clk_en <= 1'b1;
    rd(3'h3, 16'h0000);
    wr(3'h3, 16'ha5c3);
    rd(3'h3, 16'ha0c3);
    chk({11'h0, mode2}, 24'h0014c3);
    $display("test freeze done");
  endtask
  task automatic t_decode;
    dec(24'h0007ff, 2'h0);
    dec(24'h000800, 2'h1);
    dec(24'h807fff, 2'h1);
    dec(24'h808000, 2'h2);
    $display("test decode done");
  endtask
  task automatic t_zero;
    // Region 2 left idle while zeroed
    wr(3'h1, 16'h0000);
    chk({23'h0, zeroed}, 24'h000001);
    dec(24'hffffff, 2'h1);
    rd(3'h4, 16'h0005);
    wr(3'h1, 16'h8080);
    wr(3'h0, 16'h0000);
    dec(24'hffffff, 2'h2);
    rd(3'h4, 16'h0002);
    chk({23'h0, zeroed}, 24'h000000);
    $display("test zero done");
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole run is under 100 cycles; this leaves a wide margin
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_fields();
    t_freeze();
    t_decode();
    t_zero();
    give_verdict();
  end
endmodule
